// file: common/agp_pkg.sv
/*
 * Shared constants and decode helpers for the address-decoded general pins.
 * Assumes an ISA-style I/O bus and one 20 MHz clock.
 */
`default_nettype none

package agp_pkg;

	// Configuration port addresses on the I/O bus
	localparam logic [10:0] CFG_INDEX_PORT = 11'h3F0;
	localparam logic [10:0] CFG_DATA_PORT = 11'h3F1;

	// Configuration indices reachable through the data port
	localparam logic [7:0] IDX_FIRST = 8'h10;
	localparam logic [7:0] IDX_ADDR0_LO = 8'h10;
	localparam logic [7:0] IDX_ADDR0_HI = 8'h11;
	localparam logic [7:0] IDX_ADDR1_LO = 8'h12;
	localparam logic [7:0] IDX_ADDR1_HI = 8'h13;
	localparam logic [7:0] IDX_PIN0_CTRL = 8'h14;
	localparam logic [7:0] IDX_PIN1_CTRL = 8'h15;
	localparam int CFG_COUNT = 6;
	localparam int CTRL_SLOT = 4;

	// Reset values
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;

	// Control register fields
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 5;
	localparam int POL_BIT = 4;
	localparam int QRD_BIT = 3;
	localparam int QWR_BIT = 2;
	localparam int OINV_BIT = 1;
	localparam int IINV_BIT = 0;

	// Upper address register fields
	localparam int CMP_MSB = 7;
	localparam int CMP_LSB = 6;
	localparam int AHI_MSB = 2;

	// Mode encodings; any code with the top bit set is chip select
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_OUT = 3'h1;
	localparam logic [2:0] MODE_IN = 3'h2;
	localparam logic [2:0] MODE_BIDIR = 3'h3;
	localparam int MODE_CS_BIT = 2;

	// Synchroniser depth on pin inputs
	localparam int SYNC_STAGES = 2;

	function automatic logic addr_match(input logic [10:0] sa,
		input logic [10:0] base, input logic [1:0] cmp);
		logic [10:0] mask;
		mask = 11'h7FF << cmp;
		return ((sa ^ base) & mask) == 11'h000;
	endfunction

endpackage

`default_nettype wire

// file: hw/agp_general_pins.sv
/*
 * Two address-decoded general pins behind an index/data configuration port.
 * Assumes an ISA-style I/O bus whose pins are asynchronous to clk, and that
 * extended function mode is entered elsewhere and shown on config_mode.
 */
`timescale 1ns/10ps
`default_nettype none

module agp_general_pins (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// I/O bus
	input wire logic [10:0] sa,
	input wire logic aen,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [7:0] sd_in,
	output logic [7:0] sd_out,
	output logic [7:0] sd_oe,
	// Extended function mode active
	input wire logic config_mode,
	// General pins
	input wire logic [1:0] gp_in,
	output logic [1:0] gp_out,
	output logic [1:0] gp_oe
);

	localparam int SW = 25;

	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [10:0] sa_s;
	logic aen_s;
	logic ior_s;
	logic iow_s;
	logic [7:0] sd_s;
	logic cfg_s;
	logic [1:0] gp_s;

	logic [7:0] idx;
	logic [7:0] next_idx;
	logic [7:0] cfg [agp_pkg::CFG_COUNT];
	logic [7:0] next_cfg [agp_pkg::CFG_COUNT];
	logic iow_q;
	logic [10:0] sa_q;
	logic aen_q;
	logic [7:0] sd_q;
	logic [7:0] next_sd_out;
	logic [7:0] next_sd_oe;
	logic wr_done;
	logic [1:0] ch_rd_en;
	logic [1:0] ch_rd_bit;

	// Two-flop synchroniser on every pin input
	always_ff @(posedge clk) begin
		sync1 <= {sa, aen, ior_n, iow_n, sd_in, config_mode, gp_in};
		sync2 <= sync1;
	end
	assign {sa_s, aen_s, ior_s, iow_s, sd_s, cfg_s, gp_s} = sync2;

	// Selected configuration register, zero when index is unmapped
	function automatic logic [7:0] cfg_read(input logic [7:0] index,
		input logic [7:0] regs [agp_pkg::CFG_COUNT]);
		logic [7:0] slot;
		slot = index - agp_pkg::IDX_FIRST;
		if (index >= agp_pkg::IDX_FIRST &&
			slot < 8'(agp_pkg::CFG_COUNT)) begin
			return regs[slot[2:0]];
		end
		return 8'h00;
	endfunction

	// Write commits at strobe release with the last low-phase sample
	assign wr_done = !iow_q && iow_s;

	always_comb begin
		logic [7:0] slot;
		slot = idx - agp_pkg::IDX_FIRST;
		next_idx = idx;
		next_cfg = cfg;
		if (wr_done && cfg_s && !aen_q) begin
			if (agp_pkg::addr_match(sa_q, agp_pkg::CFG_INDEX_PORT, 2'h0)) begin
				next_idx = sd_q;
			end
			// Data port writes the indexed register
			if (agp_pkg::addr_match(sa_q, agp_pkg::CFG_DATA_PORT, 2'h0) &&
				idx >= agp_pkg::IDX_FIRST &&
				slot < 8'(agp_pkg::CFG_COUNT)) begin
				next_cfg[slot[2:0]] = sd_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			idx <= agp_pkg::INDEX_RESET;
			for (int i = 0; i < agp_pkg::CFG_COUNT; i++) begin
				cfg[i] <= agp_pkg::CFG_RESET;
			end
			iow_q <= 1'b1;
			sa_q <= 11'h000;
			aen_q <= 1'b1;
			sd_q <= 8'h00;
		end else begin
			idx <= next_idx;
			cfg <= next_cfg;
			iow_q <= iow_s;
			sa_q <= sa_s;
			aen_q <= aen_s;
			sd_q <= sd_s;
		end
	end

	// One channel per pin, each on its own data bit
	generate
		for (genvar g = 0; g < 2; g++) begin : g_pin
			agp_pin_channel u_channel (
				.clk(clk),
				.reset(reset),
				.ctrl(cfg[agp_pkg::CTRL_SLOT + g]),
				.base({cfg[2*g+1][agp_pkg::AHI_MSB:0], cfg[2*g]}),
				.cmp(cfg[2*g+1][agp_pkg::CMP_MSB:agp_pkg::CMP_LSB]),
				.sa(sa_s),
				.aen(aen_s),
				.ior_n(ior_s),
				.iow_n(iow_s),
				.sd_bit(sd_s[g]),
				.pin_in(gp_s[g]),
				.pin_out(gp_out[g]),
				.pin_oe(gp_oe[g]),
				.rd_en(ch_rd_en[g]),
				.rd_bit(ch_rd_bit[g])
			);
		end
	endgenerate

	always_comb begin
		next_sd_out = 8'h00;
		next_sd_oe = 8'h00;
		if (!aen_s && !ior_s) begin
			if (cfg_s &&
				agp_pkg::addr_match(sa_s, agp_pkg::CFG_INDEX_PORT, 2'h0)) begin
				next_sd_out = idx;
				next_sd_oe = 8'hFF;
			end else if (cfg_s &&
				agp_pkg::addr_match(sa_s, agp_pkg::CFG_DATA_PORT, 2'h0)) begin
				next_sd_out = cfg_read(idx, cfg);
				next_sd_oe = 8'hFF;
			end else begin
				for (int i = 0; i < 2; i++) begin
					next_sd_out[i] = ch_rd_en[i] & ch_rd_bit[i];
					next_sd_oe[i] = ch_rd_en[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sd_out <= 8'h00;
			sd_oe <= 8'h00;
		end else begin
			sd_out <= next_sd_out;
			sd_oe <= next_sd_oe;
		end
	end

	reset_clear_a: assert property (@(posedge clk)
		reset |=> (cfg[4] == 8'h00 && cfg[5] == 8'h00 && gp_oe == 2'b00))
		else $error("control not cleared by reset");

	ctrl_write_a: assert property (@(posedge clk) disable iff (reset)
		(wr_done && cfg_s && !aen_q && sa_q == 11'h3F1 && idx == 8'h14)
		|=> cfg[4] == $past(sd_q))
		else $error("pin-0 control write lost");

	sd_release_a: assert property (@(posedge clk) disable iff (reset)
		(sd_oe != 8'h00) |-> (!$past(ior_s) && !$past(aen_s)))
		else $error("bus driven outside a read");

	cfg_read_a: assert property (@(posedge clk) disable iff (reset)
		(!aen_s && !ior_s && cfg_s && sa_s == 11'h3F1 && idx == 8'h15 &&
		$stable(cfg[5])) |=> (sd_oe == 8'hFF && sd_out == cfg[5]))
		else $error("pin-1 control read wrong");

	pin1_read_a: assert property (@(posedge clk) disable iff (reset)
		(ch_rd_en[1] && !cfg_s) |=>
		(sd_oe[1] && sd_out[1] == $past(ch_rd_bit[1])))
		else $error("pin-1 read not on bit one");

endmodule

`default_nettype wire

// file: hw/agp_pin_channel.sv
/*
 * One general pin: data output, input, bidirectional or chip select.
 * Assumes all bus and pin inputs arrive already synchronised to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module agp_pin_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration
	input wire logic [7:0] ctrl,
	input wire logic [10:0] base,
	input wire logic [1:0] cmp,
	// Synchronised bus
	input wire logic [10:0] sa,
	input wire logic aen,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic sd_bit,
	// Synchronised pin level
	input wire logic pin_in,
	// Pin drive
	output logic pin_out,
	output logic pin_oe,
	// Read data toward the bus
	output logic rd_en,
	output logic rd_bit
);

	logic next_pin_out;
	logic next_pin_oe;
	logic hit;
	logic qual;
	logic cs_act;
	logic [2:0] mode;

	assign mode = ctrl[agp_pkg::MODE_MSB:agp_pkg::MODE_LSB];
	assign hit = !aen && agp_pkg::addr_match(sa, base, cmp);

	always_comb begin
		case ({ctrl[agp_pkg::QRD_BIT], ctrl[agp_pkg::QWR_BIT]})
			2'b00: qual = 1'b1;
			2'b01: qual = !iow_n;
			2'b10: qual = !ior_n;
			default: qual = !iow_n || !ior_n;
		endcase
	end
	assign cs_act = hit && qual;

	always_comb begin
		next_pin_out = pin_out;
		next_pin_oe = 1'b0;
		if (mode[agp_pkg::MODE_CS_BIT]) begin
			next_pin_oe = 1'b1;
			next_pin_out = ctrl[agp_pkg::POL_BIT] ? cs_act : !cs_act;
		end else begin
			case (mode)
				agp_pkg::MODE_OUT: begin
					next_pin_oe = 1'b1;
					if (hit && !iow_n) begin
						next_pin_out = sd_bit ^ ctrl[agp_pkg::OINV_BIT];
					end
				end
				agp_pkg::MODE_BIDIR: begin
					if (hit && !iow_n) begin
						next_pin_oe = 1'b1;
						next_pin_out = sd_bit ^ ctrl[agp_pkg::OINV_BIT];
					end
				end
				default: next_pin_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	assign rd_en = hit && !ior_n &&
		(mode == agp_pkg::MODE_IN || mode == agp_pkg::MODE_BIDIR);
	assign rd_bit = pin_in ^ ctrl[agp_pkg::IINV_BIT];

	off_release_a: assert property (@(posedge clk) disable iff (reset)
		(mode == agp_pkg::MODE_OFF) |=> !pin_oe)
		else $error("pin driven while off");

	cs_level_a: assert property (@(posedge clk) disable iff (reset)
		(mode[2] && ctrl[4] && $stable(ctrl)) |=> (pin_oe && pin_out == $past(cs_act)))
		else $error("active-high select level wrong");

	cs_low_a: assert property (@(posedge clk) disable iff (reset)
		(mode[2] && !ctrl[4] && hit && qual) |=> (pin_oe && !pin_out))
		else $error("active-low select not asserted");

	out_write_a: assert property (@(posedge clk) disable iff (reset)
		(mode == 3'h1 && hit && !iow_n) |=>
		(pin_out == ($past(sd_bit) ^ $past(ctrl[1]))))
		else $error("output pin did not take bus bit");

	bidir_drive_a: assert property (@(posedge clk) disable iff (reset)
		(mode == 3'h3) |=> (pin_oe == ($past(hit) && !$past(iow_n))))
		else $error("bidirectional drive wrong");

	read_mode_a: assert property (@(posedge clk) disable iff (reset)
		rd_en |-> (!mode[2] && mode[1] && !ior_n && !aen))
		else $error("read enabled outside input modes");

endmodule

`default_nettype wire

// file: verification/agp_host.sv
/*
 * Bus host model that issues I/O reads and writes to the general pins.
 * Assumes the bench resolves the data and pin wires and feeds them back.
 */
`timescale 1ns/10ps
`default_nettype none

module agp_host (
	// Clock
	input wire logic clk,
	// Bus drive
	output logic [10:0] sa,
	output logic aen,
	output logic ior_n,
	output logic iow_n,
	output logic [7:0] dq,
	// Resolved wires
	input wire logic [7:0] sd,
	input wire logic [1:0] gp_pin
);
	initial begin
		sa = 11'h000;
		aen = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		dq = 8'hFF;
	end

	task automatic io(input logic wr, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] rd, output logic [1:0] gp);
		@(posedge clk);
		sa <= a;
		aen <= 1'b0;
		// Reads leave the data lines to their pull-ups
		dq <= wr ? d : 8'hFF;
		if (wr) begin
			iow_n <= 1'b0;
		end else begin
			ior_n <= 1'b0;
		end
		repeat (5) @(posedge clk);
		#1;
		rd = sd;
		gp = gp_pin;
		@(posedge clk);
		iow_n <= 1'b1;
		ior_n <= 1'b1;
		@(posedge clk);
		aen <= 1'b1;
		dq <= ~d;
		sa <= ~a;
		repeat (3) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
/*
 * Self-checking bench for the general pins: configures, then drives cycles.
 * Assumes the host model and the design share one 20 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_top;
	logic clk, reset, config_mode;
	logic [1:0] gp_drv, gp_out, gp_oe, gp, g;
	logic [7:0] sd_out, sd_oe, dq, sd, rd;
	logic [10:0] sa;
	logic aen, ior_n, iow_n;
	int n_errors = 0;
	int num_checks = 0;

	assign sd = (sd_oe & sd_out) | (~sd_oe & dq);
	assign gp = (gp_oe & gp_out) | (~gp_oe & gp_drv);

	agp_general_pins dut (.clk(clk), .reset(reset), .sa(sa), .aen(aen),
		.ior_n(ior_n), .iow_n(iow_n), .sd_in(sd), .sd_out(sd_out),
		.sd_oe(sd_oe), .config_mode(config_mode), .gp_in(gp),
		.gp_out(gp_out), .gp_oe(gp_oe));
	agp_host host (.clk(clk), .sa(sa), .aen(aen), .ior_n(ior_n),
		.iow_n(iow_n), .dq(dq), .sd(sd), .gp_pin(gp));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
		host.io(1'b1, agp_pkg::CFG_INDEX_PORT, idx, rd, g);
		host.io(1'b1, agp_pkg::CFG_DATA_PORT, val, rd, g);
	endtask

	task automatic cfg_rd(input logic [7:0] idx);
		host.io(1'b1, agp_pkg::CFG_INDEX_PORT, idx, rd, g);
		host.io(1'b0, agp_pkg::CFG_DATA_PORT, 8'h00, rd, g);
	endtask

	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		config_mode = 1'b1;
		gp_drv = 2'h0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		cfg_rd(8'h14);
		`CHK("pin0 ctrl reset", 8'h00, rd)
		cfg_rd(8'h15);
		`CHK("pin1 ctrl reset", 8'h00, rd)
		`CHK("pins undriven", 2'h0, gp_oe)
		config_mode <= 1'b0;
		cfg(8'h14, 8'h20);
		config_mode <= 1'b1;
		cfg_rd(8'h14);
		`CHK("write outside mode", 8'h00, rd)
		cfg(8'h10, 8'h00);
		cfg(8'h11, 8'h03);
		cfg(8'h14, 8'h20);
		cfg_rd(8'h14);
		`CHK("pin0 ctrl readback", 8'h20, rd)
		host.io(1'b1, 11'h300, 8'h01, rd, g);
		`CHK("out mode pin", 1'b1, g[0])
		`CHK("out mode drive", 1'b1, gp_oe[0])
		host.io(1'b1, 11'h301, 8'h00, rd, g);
		`CHK("mismatch ignored", 1'b1, gp_out[0])
		cfg(8'h14, 8'h41);
		gp_drv <= 2'h1;
		host.io(1'b0, 11'h300, 8'h00, rd, g);
		`CHK("in mode inverted", 1'b0, rd[0])
		`CHK("in mode released", 1'b0, gp_oe[0])
		`CHK("bus released", 8'h00, sd_oe)
		cfg(8'h12, 8'h10);
		cfg(8'h13, 8'h83);
		cfg(8'h15, 8'h98);
		host.io(1'b0, 11'h313, 8'h00, rd, g);
		`CHK("select on read", 1'b1, g[1])
		host.io(1'b1, 11'h313, 8'h00, rd, g);
		`CHK("select needs read", 1'b0, g[1])
		host.io(1'b0, 11'h314, 8'h00, rd, g);
		`CHK("outside window", 1'b0, g[1])
		cfg(8'h15, 8'h8C);
		host.io(1'b1, 11'h312, 8'h00, rd, g);
		`CHK("select active low", 1'b0, g[1])
		cfg(8'h14, 8'h94);
		host.io(1'b1, 11'h300, 8'h00, rd, g);
		`CHK("pin0 select high", 1'b1, g[0])
		host.io(1'b0, 11'h300, 8'h00, rd, g);
		`CHK("pin0 needs write", 1'b0, g[0])
		cfg(8'h15, 8'hB0);
		host.io(1'b0, 11'h311, 8'h00, rd, g);
		`CHK("select address only", 1'b1, g[1])
		cfg(8'h13, 8'h03);
		cfg(8'h15, 8'h62);
		gp_drv <= 2'h2;
		host.io(1'b1, 11'h310, 8'h02, rd, g);
		`CHK("bidir out inverted", 1'b0, g[1])
		`CHK("bidir idle", 1'b0, gp_oe[1])
		gp_drv <= 2'h0;
		host.io(1'b0, 11'h310, 8'h00, rd, g);
		`CHK("bidir read sd1", 1'b0, rd[1])
		print_verdict();
	end
endmodule

`default_nettype wire
